// file: twi_status_pins.sv
// Two-wire bus controller common part: pins, status word, soft reset
//
// Overview of operation
// R01 - Transmit lock set: bus-side read is held off by stretching clock
// R02 - Transmit lock sets on STOP or restart as slave sender; clears on empty
// R03 - Receive lock set: bus-side write is held off by stretching clock
// R04 - Receive lock sets on master arbitration loss or slave-receiver STOP/restart
// R05 - Status bits 3 and 2 show sampled data and clock levels
// R06 - Bus-in-use bit sets on START, clears on STOP
// R07 - Status bit 0 is 1 in master role, 0 in slave role
// R08 - Bus on pins five/four open-drain, or pins two/three push-pull
// R09 - Per-line enabled filter rejects spikes up to 60 ns
// R10 - Slew limiting enabled separately for data and clock outputs
// R11 - After reset pins four and five are dedicated bus cells
// R12 - Multi-function mode drops open-drain, filtering and slew together
// R13 - Soft reset command reinitialises bus logic without device reset
// R14 - Master enable clears interrupt flags and reinitialises both queues
// R15 - Status bits 9..4 give full/empty of slave send, send, receive queues
// R16 - Status bits 31..16 read zero
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module twi_status_pins
   import twi_pkg::*;
(
   input wire logic I_CORE_CLK,
   input wire logic I_RST,
   input wire logic [ADDR_W-1:0] I_ADDR,
   input wire logic [31:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [31:0] O_RDATA,
   output logic O_IRQ,
   input wire logic I_SDA_PULL_LOW,
   input wire logic I_SCL_PULL_LOW,
   input wire logic I_SLV_SEND,
   input wire logic I_ARB_LOST,
   input wire logic I_BUS_RD_ATTEMPT,
   input wire logic I_BUS_WR_ATTEMPT,
   input wire logic I_SLAVE_SEND_QUEUE_FULL,
   input wire logic I_SLAVE_SEND_QUEUE_EMPTY,
   input wire logic I_TXQ_FULL,
   input wire logic I_TXQ_EMPTY,
   input wire logic I_RXQ_FULL,
   input wire logic I_RXQ_EMPTY,
   output logic O_SCL_STRETCH,
   output logic O_SOFT_RESET,
   output logic O_QUEUE_INIT,
   output logic O_MASTER_ROLE,
   output logic O_SDA,
   output logic O_SCL,
   input wire logic I_GENERAL_PIN_TWO,
   output logic O_GENERAL_PIN_TWO,
   output logic O_GENERAL_PIN_TWO_OE,
   input wire logic I_GENERAL_PIN_THREE,
   output logic O_GENERAL_PIN_THREE,
   output logic O_GENERAL_PIN_THREE_OE,
   input wire logic I_GENERAL_PIN_FOUR,
   output logic O_GENERAL_PIN_FOUR,
   output logic O_GENERAL_PIN_FOUR_OE,
   input wire logic I_GENERAL_PIN_FIVE,
   output logic O_GENERAL_PIN_FIVE,
   output logic O_GENERAL_PIN_FIVE_OE,
   output logic O_PINS45_OPEN_DRAIN,
   output logic O_SDA_SLEW_LIMIT,
   output logic O_SCL_SLEW_LIMIT,
   output logic O_MULTI_FUNCTION_PIN_MODE
);
   // ==========================================================
   // Register decode
   logic [CFG_W-1:0] cfg;
   logic master;
   logic [EV_W-1:0] int_status, int_mask;
   logic tx_lock, rx_lock;
   logic soft_rst;
   wire sel_cfg = (I_ADDR == OFS_CONFIG);
   wire sel_ctl = (I_ADDR == OFS_CONTROL);
   wire sel_st = (I_ADDR == OFS_STATUS);
   wire sel_is = (I_ADDR == OFS_INT_STATUS);
   wire sel_im = (I_ADDR == OFS_INT_MASK);
   wire wr_ctl = I_WR && sel_ctl;
   wire soft_cmd = wr_ctl && I_WDATA[CTL_SOFT_RST];
   wire master_on = wr_ctl && I_WDATA[CTL_MASTER] && !master;
   wire bus_rst = I_RST || soft_rst; // R13
   // ==========================================================
   // Pin routing and cell control
   wire multi_function_pin_mode = cfg[CFG_MULTI_FUNCTION_PIN_MODE];
   wire use45 = cfg[CFG_OD_PINS] && !multi_function_pin_mode; // R08
   // Pins four/five default to bus cells; multi-function drops all specials
   assign O_MULTI_FUNCTION_PIN_MODE = multi_function_pin_mode; // R11
   assign O_PINS45_OPEN_DRAIN = use45; // R12
   assign O_SDA_SLEW_LIMIT = !cfg[CFG_SDA_SLEW_DIS] && !multi_function_pin_mode; // R10 R12
   assign O_SCL_SLEW_LIMIT = !cfg[CFG_SCL_SLEW_DIS] && !multi_function_pin_mode; // R10 R12
   wire sda_filt_en = cfg[CFG_SDA_FILT] && !multi_function_pin_mode; // R12
   wire scl_filt_en = cfg[CFG_SCL_FILT] && !multi_function_pin_mode; // R12
   wire scl_low = I_SCL_PULL_LOW || O_SCL_STRETCH;
   // Open-drain pins only ever pull low; others drive both levels
   assign O_GENERAL_PIN_FIVE = 1'b0;
   assign O_GENERAL_PIN_FIVE_OE = use45 && I_SDA_PULL_LOW; // R08
   assign O_GENERAL_PIN_FOUR = 1'b0;
   assign O_GENERAL_PIN_FOUR_OE = use45 && scl_low; // R08
   assign O_GENERAL_PIN_TWO = !I_SDA_PULL_LOW;
   assign O_GENERAL_PIN_TWO_OE = !use45; // R08
   assign O_GENERAL_PIN_THREE = !scl_low;
   assign O_GENERAL_PIN_THREE_OE = !use45; // R08
   wire sda_pin = use45 ? I_GENERAL_PIN_FIVE : I_GENERAL_PIN_TWO;
   wire scl_pin = use45 ? I_GENERAL_PIN_FOUR : I_GENERAL_PIN_THREE;
   // ==========================================================
   // Line conditioning and bus conditions
   logic sda_f, scl_f, start, stop, active;
   twi_line_cond #(.FILT(FILT_CYC)) u_sda (
      .i_clk(I_CORE_CLK),
      .i_rst(I_RST),
      .i_line(sda_pin),
      .i_filt_en(sda_filt_en),
      .o_level(sda_f)
   );
   twi_line_cond #(.FILT(FILT_CYC)) u_scl (
      .i_clk(I_CORE_CLK),
      .i_rst(I_RST),
      .i_line(scl_pin),
      .i_filt_en(scl_filt_en),
      .o_level(scl_f)
   );
   twi_bus_cond u_cond (
      .i_clk(I_CORE_CLK),
      .i_rst(bus_rst),
      .i_sda(sda_f),
      .i_scl(scl_f),
      .o_start(start),
      .o_stop(stop),
      .o_active(active)
   );
   assign O_SDA = sda_f;
   assign O_SCL = scl_f;
   // ==========================================================
   // Queue locks and clock stretching
   wire stop_or_re = stop || (start && active);
   wire tx_set = !master && I_SLV_SEND && stop_or_re; // R02
   wire rx_set = (master && I_ARB_LOST) || (!master && !I_SLV_SEND && stop_or_re); // R04
   // Lock asserts even if the queue is already empty; clears a cycle later
   always_ff @(posedge I_CORE_CLK) begin
      if (bus_rst) begin
         tx_lock <= 1'b0;
         rx_lock <= 1'b0;
      end else begin
         tx_lock <= tx_set || (tx_lock && !I_TXQ_EMPTY); // R02
         rx_lock <= rx_set || (rx_lock && !I_RXQ_EMPTY); // R04
      end
   end
   assign O_SCL_STRETCH = (tx_lock && I_BUS_RD_ATTEMPT) || (rx_lock && I_BUS_WR_ATTEMPT); // R01 R03
   assign O_MASTER_ROLE = master;
   // ==========================================================
   // Control and configuration registers
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         cfg <= CFG_RESET; // R11
         master <= 1'b0;
         soft_rst <= 1'b0;
         O_QUEUE_INIT <= 1'b0;
      end else begin
         if (I_WR && sel_cfg) cfg <= I_WDATA[CFG_W-1:0];
         if (wr_ctl) master <= I_WDATA[CTL_MASTER]; // R07
         soft_rst <= soft_cmd; // R13
         O_QUEUE_INIT <= master_on; // R14
      end
   end
   assign O_SOFT_RESET = soft_rst;
   // ==========================================================
   // Interrupts
   wire [EV_W-1:0] events = {rx_set, tx_set, stop, start};
   wire [EV_W-1:0] w1c = (I_WR && sel_is) ? I_WDATA[EV_W-1:0] : '0;
   wire [EV_W-1:0] keep = master_on ? '0 : (int_status & ~w1c); // R14
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         int_status <= '0;
         int_mask <= '0;
      end else begin
         int_status <= events | keep;
         if (I_WR && sel_im) int_mask <= I_WDATA[EV_W-1:0];
      end
   end
   assign O_IRQ = |(int_status & int_mask);
   // ==========================================================
   // Status word and read data
   wire [31:0] status = {16'h0000, 4'h0, tx_lock, rx_lock, // R16 R01 R03
      I_SLAVE_SEND_QUEUE_FULL, I_SLAVE_SEND_QUEUE_EMPTY, I_TXQ_FULL, I_TXQ_EMPTY, // R15
      I_RXQ_FULL, I_RXQ_EMPTY, sda_f, scl_f, active, master}; // R15 R05 R06 R07
   wire [31:0] rd_mux = sel_cfg ? {26'h0, cfg} :
      sel_ctl ? {30'h0, master, 1'b0} :
      sel_st ? status :
      sel_is ? {28'h0, int_status} :
      sel_im ? {28'h0, int_mask} : 32'h0;
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) O_RDATA <= 32'h0;
      else O_RDATA <= I_RD ? rd_mux : 32'h0;
   end
   // ==========================================================
   // Checks
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_RST);
   tx_stretch_a: assert property (tx_lock && I_BUS_RD_ATTEMPT |-> O_SCL_STRETCH) // R01
      else $error("Read not stretched under transmit lock");
   tx_lock_set_a: assert property (tx_set && !soft_rst |=> tx_lock ##0 $past(master) == 1'b0) // R02
      else $error("Transmit lock not set");
   tx_lock_clr_a: assert property (tx_lock && I_TXQ_EMPTY && !tx_set |=> !tx_lock) // R02
      else $error("Transmit lock not cleared on empty");
   rx_stretch_a: assert property (rx_lock && I_BUS_WR_ATTEMPT |-> O_SCL_STRETCH) // R03
      else $error("Write not stretched under receive lock");
   rx_lock_set_a: assert property (master && I_ARB_LOST && !soft_rst |=> rx_lock) // R04
      else $error("Receive lock not set on arbitration loss");
   line_level_a: assert property (I_RD && sel_st |=> O_RDATA[3:2] == $past({sda_f, scl_f})) // R05
      else $error("Line levels wrong in status");
   bus_active_a: assert property (start && !soft_rst |=> active ##1 (active || $past(stop))) // R06
      else $error("Bus-in-use not set on start");
   bus_idle_a: assert property (stop && !soft_rst |=> !active) // R06
      else $error("Bus-in-use not cleared on stop");
   role_bit_a: assert property (wr_ctl |=> O_MASTER_ROLE == $past(I_WDATA[CTL_MASTER])) // R07
      else $error("Role bit does not follow control write");
   od_drive_a: assert property (use45 && I_SDA_PULL_LOW |-> O_GENERAL_PIN_FIVE_OE && !O_GENERAL_PIN_FIVE) // R08
      else $error("Open-drain data not pulled low");
   reset_cells_a: assert property ($fell(I_RST) |-> O_PINS45_OPEN_DRAIN && !multi_function_pin_mode) // R11
      else $error("Pins four and five not bus cells after reset");
   multi_function_pin_mode_off_a: assert property (multi_function_pin_mode |-> !O_PINS45_OPEN_DRAIN && !O_SDA_SLEW_LIMIT && !sda_filt_en) // R12
      else $error("Multi-function mode left specials on");
   soft_reset_a: assert property (soft_cmd |=> ##1 !active && !tx_lock && !rx_lock) // R13
      else $error("Soft reset did not clear bus logic");
   master_init_a: assert property (master_on |=> O_QUEUE_INIT && (int_status == $past(events))) // R14
      else $error("Master enable did not init queues and flags");
   reserved_a: assert property (I_RD |=> O_RDATA[31:16] == 16'h0000) // R16
      else $error("Reserved status bits not zero");
   start_seen_c: cover property (start ##[1:1000] stop);
   tx_hold_c: cover property (tx_lock && I_BUS_RD_ATTEMPT);
   rx_arb_c: cover property (master && I_ARB_LOST ##1 rx_lock);
   irq_c: cover property (O_IRQ);
endmodule : twi_status_pins
`default_nettype wire

// file: twi_pkg.sv
// Constants shared by the two-wire bus status and pin logic
`default_nettype none
package twi_pkg;
   // ==========================================================
   // Clock and timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int GLITCH_NS = 60;
   // Longest time, rounded down, never below one cycle
   localparam int FILT_CYC = (GLITCH_NS / CLK_PERIOD_NS) < 1 ? 1 : GLITCH_NS / CLK_PERIOD_NS;
   // ==========================================================
   // Register offsets
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_CONFIG = 8'h00;
   localparam logic [7:0] OFS_CONTROL = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_INT_STATUS = 8'h0c;
   localparam logic [7:0] OFS_INT_MASK = 8'h10;
   // ==========================================================
   // Configuration fields
   localparam int CFG_SDA_FILT = 0;
   localparam int CFG_SCL_FILT = 1;
   localparam int CFG_SDA_SLEW_DIS = 2;
   localparam int CFG_SCL_SLEW_DIS = 3;
   localparam int CFG_OD_PINS = 4;
   localparam int CFG_MULTI_FUNCTION_PIN_MODE = 5;
   localparam int CFG_W = 6;
   localparam logic [5:0] CFG_RESET = 6'h13;
   // ==========================================================
   // Control fields
   localparam int CTL_SOFT_RST = 0;
   localparam int CTL_MASTER = 1;
   // ==========================================================
   // Status fields
   localparam int ST_ROLE = 0;
   localparam int ST_ACTIVE = 1;
   localparam int ST_SCL = 2;
   localparam int ST_SDA = 3;
   localparam int ST_RXQ_EMPTY = 4;
   localparam int ST_RXQ_FULL = 5;
   localparam int ST_TXQ_EMPTY = 6;
   localparam int ST_TXQ_FULL = 7;
   localparam int ST_TXSQ_EMPTY = 8;
   localparam int ST_TXSQ_FULL = 9;
   localparam int ST_RX_LOCK = 10;
   localparam int ST_TX_LOCK = 11;
   // ==========================================================
   // Interrupt events
   localparam int EV_START = 0;
   localparam int EV_STOP = 1;
   localparam int EV_TX_LOCK = 2;
   localparam int EV_RX_LOCK = 3;
   localparam int EV_W = 4;
endpackage : twi_pkg
`default_nettype wire

// file: twi_line_cond.sv
// Line input synchroniser with optional spike filter
`timescale 1ns/10ps
`default_nettype none
module twi_line_cond
   import twi_pkg::*;
#(
   parameter int FILT = FILT_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_line,
   input wire logic i_filt_en,
   output logic o_level
);
   initial begin
      if (FILT < 1 || FILT > 15) $error("Filter length out of range");
   end
   logic s1, s2, s3;
   logic [3:0] cnt;
   wire agree = (s2 == s3);
   wire differ = agree && (s3 != o_level);
   // Change must outlast FILT cycles to pass
   wire take = differ && (!i_filt_en || cnt == 4'(FILT)); // R09
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         {s1, s2, s3} <= 3'h7;
         cnt <= 4'h0;
         o_level <= 1'b1;
      end else begin
         s1 <= i_line;
         s2 <= s1;
         s3 <= s2;
         cnt <= (differ && !take) ? cnt + 4'h1 : 4'h0; // R09
         if (take) o_level <= s3;
      end
   end
endmodule : twi_line_cond
`default_nettype wire

// file: twi_bus_cond.sv
// START and STOP detection and bus-in-use flag
`timescale 1ns/10ps
`default_nettype none
module twi_bus_cond (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_sda,
   input wire logic i_scl,
   output logic o_start,
   output logic o_stop,
   output logic o_active
);
   logic sda_d;
   assign o_start = i_scl && sda_d && !i_sda;
   assign o_stop = i_scl && !sda_d && i_sda;
   // Tap runs through reset, so a soft reset with data low fakes no START
   always_ff @(posedge i_clk) begin
      sda_d <= i_sda;
      if (i_rst) begin
         o_active <= 1'b0;
      end else begin
         if (o_start) o_active <= 1'b1; // R06
         else if (o_stop) o_active <= 1'b0; // R06
      end
   end
endmodule : twi_bus_cond
`default_nettype wire

// file: twi_peer.sv
// Far-side bus devices on the two-wire bus: pull-ups, pulls and conditions
`timescale 1ns/10ps
`default_nettype none
module twi_peer (
   input wire logic [5:2] i_out,
   input wire logic [5:2] i_oe,
   output logic [5:2] o_pin
);
   // ==========================================================
   // Wire levels
   // Both lines carry pull-ups, so a released line reads high
   logic sda_low = 1'b0;
   logic scl_low = 1'b0;
   assign o_pin[5] = !(i_oe[5] && !i_out[5]) && !sda_low;
   assign o_pin[4] = !(i_oe[4] && !i_out[4]) && !scl_low;
   // Push-pull cells win over the far side; it cannot pull them
   assign o_pin[2] = i_oe[2] ? i_out[2] : !sda_low;
   assign o_pin[3] = i_oe[3] ? i_out[3] : !scl_low;
   // ==========================================================
   // Conditions, clocked at 160 ns inside frames only
   // Each task steps off the sampling edge before moving a line
   task start();
      #3;
      sda_low = 1'b1;
      #80;
   endtask : start
   task clk_bits(input int n);
      #3;
      repeat (n) begin
         scl_low = 1'b1;
         #80;
         scl_low = 1'b0;
         #80;
      end
   endtask : clk_bits
   task stop();
      #3;
      scl_low = 1'b1;
      sda_low = 1'b1;
      #80;
      scl_low = 1'b0;
      #80;
      sda_low = 1'b0;
      #80;
   endtask : stop
   task spike(input int t);
      #3;
      sda_low = 1'b1;
      #(t);
      sda_low = 1'b0;
      #80;
   endtask : spike
endmodule : twi_peer
`default_nettype wire

// file: tb.sv
// Self-checking bench for the bus status and pin block
`timescale 1ns/10ps
`default_nettype none
module tb;
   import twi_pkg::*;
   // ==========================================================
   // Signals
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic sda_pl = 1'b0;
   logic scl_pl = 1'b0;
   logic slv_send = 1'b0;
   logic arb = 1'b0;
   logic rd_att = 1'b0;
   logic wr_att = 1'b0;
   logic [5:0] q = 6'h15;
   logic [31:0] rdata;
   logic irq, stretch, srst, qinit, mrole, osda, oscl, od, sslew, cslew, mfm;
   logic [5:2] po, poe, pin;
   int error_cnt = 0;
   int checked = 0;
   int cnt_sr = 0;
   int cnt_qi = 0;
   int cycles = 0;
   logic [31:0] d;
   initial begin
      forever #10 clk = ~clk;
   end
   twi_peer peer (.i_out(po), .i_oe(poe), .o_pin(pin));
   twi_status_pins dut_u (.I_CORE_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_IRQ(irq), .I_SDA_PULL_LOW(sda_pl),
      .I_SCL_PULL_LOW(scl_pl), .I_SLV_SEND(slv_send), .I_ARB_LOST(arb),
      .I_BUS_RD_ATTEMPT(rd_att), .I_BUS_WR_ATTEMPT(wr_att),
      .I_SLAVE_SEND_QUEUE_FULL(q[5]), .I_SLAVE_SEND_QUEUE_EMPTY(q[4]), .I_TXQ_FULL(q[3]),
      .I_TXQ_EMPTY(q[2]), .I_RXQ_FULL(q[1]), .I_RXQ_EMPTY(q[0]), .O_SCL_STRETCH(stretch),
      .O_SOFT_RESET(srst), .O_QUEUE_INIT(qinit), .O_MASTER_ROLE(mrole), .O_SDA(osda),
      .O_SCL(oscl), .I_GENERAL_PIN_TWO(pin[2]), .O_GENERAL_PIN_TWO(po[2]),
      .O_GENERAL_PIN_TWO_OE(poe[2]), .I_GENERAL_PIN_THREE(pin[3]),
      .O_GENERAL_PIN_THREE(po[3]), .O_GENERAL_PIN_THREE_OE(poe[3]),
      .I_GENERAL_PIN_FOUR(pin[4]), .O_GENERAL_PIN_FOUR(po[4]),
      .O_GENERAL_PIN_FOUR_OE(poe[4]), .I_GENERAL_PIN_FIVE(pin[5]),
      .O_GENERAL_PIN_FIVE(po[5]), .O_GENERAL_PIN_FIVE_OE(poe[5]),
      .O_PINS45_OPEN_DRAIN(od), .O_SDA_SLEW_LIMIT(sslew), .O_SCL_SLEW_LIMIT(cslew),
      .O_MULTI_FUNCTION_PIN_MODE(mfm));
   // ==========================================================
   // Pulse counters and hang guard
   always @(posedge clk) begin
      if (srst === 1'b1) cnt_sr <= cnt_sr + 1;
      if (qinit === 1'b1) cnt_qi <= cnt_qi + 1;
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         error_cnt++;
         stop_test();
      end
   end
   // ==========================================================
   // Tasks
   task stop_test();
      $display("Checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   // Read data stand one cycle only, so sample just after that edge
   task rchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, e);
   endtask : rchk
   // ==========================================================
   // Main sequence
   initial begin
      cyc(3);
      rst <= 1'b0;
      cyc(10);
      rchk(OFS_CONFIG, 32'h13);
      chk({od, mfm, sslew, cslew}, 32'hb);
      rchk(OFS_STATUS, 32'h15c);
      q <= 6'h2a;
      rchk(OFS_STATUS, 32'h2ac);
      q <= 6'h15;
      rchk(8'h20, 32'h0);
      wr_reg(OFS_STATUS, 32'hffffffff);
      rchk(OFS_STATUS, 32'h15c);
      wr_reg(OFS_INT_MASK, 32'h1);
      peer.start();
      cyc(10);
      rchk(OFS_STATUS, 32'h156);
      chk(irq, 1'b1);
      chk({osda, oscl}, 32'h1);
      wr_reg(OFS_INT_MASK, 32'h0);
      cyc(1);
      chk(irq, 1'b0);
      peer.clk_bits(4);
      peer.stop();
      cyc(10);
      rchk(OFS_STATUS, 32'h15c);
      rchk(OFS_INT_STATUS, 32'hb);
      wr_reg(OFS_INT_STATUS, 32'hb);
      rchk(OFS_INT_STATUS, 32'h0);
      // Longest spike, filter on, then off
      peer.spike(60);
      cyc(10);
      rchk(OFS_INT_STATUS, 32'h0);
      wr_reg(OFS_CONFIG, 32'h12);
      peer.spike(60);
      cyc(10);
      rchk(OFS_INT_STATUS, 32'hb);
      wr_reg(OFS_CONFIG, 32'h13);
      wr_reg(OFS_CONTROL, 32'h2);
      cyc(3);
      chk(cnt_qi, 1);
      chk(mrole, 1'b1);
      rchk(OFS_INT_STATUS, 32'h0);
      rchk(OFS_STATUS, 32'h15d);
      q <= 6'h14;
      @(posedge clk) arb <= 1'b1;
      @(posedge clk) arb <= 1'b0;
      cyc(2);
      rchk(OFS_STATUS, 32'h54d);
      rchk(OFS_INT_STATUS, 32'h8);
      wr_att <= 1'b1;
      cyc(1);
      chk(stretch, 1'b1);
      q <= 6'h15;
      cyc(3);
      chk(stretch, 1'b0);
      wr_att <= 1'b0;
      rchk(OFS_STATUS, 32'h15d);
      wr_reg(OFS_CONTROL, 32'h0);
      slv_send <= 1'b1;
      q <= 6'h11;
      peer.start();
      peer.clk_bits(2);
      peer.stop();
      cyc(10);
      rchk(OFS_STATUS, 32'h91c);
      rchk(OFS_INT_STATUS, 32'hf);
      rd_att <= 1'b1;
      cyc(1);
      chk(stretch, 1'b1);
      q <= 6'h15;
      cyc(3);
      chk(stretch, 1'b0);
      rd_att <= 1'b0;
      rchk(OFS_STATUS, 32'h15c);
      peer.start();
      cyc(10);
      wr_reg(OFS_CONTROL, 32'h1);
      cyc(3);
      chk(cnt_sr, 1);
      rchk(OFS_STATUS, 32'h154);
      rchk(OFS_CONFIG, 32'h13);
      peer.stop();
      cyc(10);
      sda_pl <= 1'b1;
      cyc(1);
      chk({poe[5], po[5], poe[4]}, 32'h4);
      scl_pl <= 1'b1;
      cyc(1);
      chk(poe[4], 1'b1);
      scl_pl <= 1'b0;
      wr_reg(OFS_CONFIG, 32'h0c);
      cyc(1);
      chk({od, sslew, cslew, poe, po[3:2]}, 32'h0e);
      sda_pl <= 1'b0;
      wr_reg(OFS_CONFIG, 32'h04);
      cyc(1);
      chk({sslew, cslew}, 32'h1);
      wr_reg(OFS_CONFIG, 32'h33);
      cyc(1);
      chk({od, mfm, sslew, cslew, poe[5:4]}, 32'h10);
      stop_test();
   end
endmodule : tb
`default_nettype wire
